/* File: rtl/ipw_pkg.sv */
package ipw_pkg;
  localparam int IRQ_NUM = 47;
  localparam int PRIO_W = 4;
  localparam int ID_W = 6;
  localparam int GRP_W = 3;
  localparam int PRIO_LSB = 4;
  localparam int CTRL_EOP_BIT = 0;
  localparam int CTRL_GRP_LSB = 8;
  localparam int PRIO_MAX_GRP = 3;
  localparam logic [31:0] A_ISER = 32'hE000_E100;
  localparam logic [31:0] A_ICER = 32'hE000_E180;
  localparam logic [31:0] A_ISPR = 32'hE000_E200;
  localparam logic [31:0] A_ICPR = 32'hE000_E280;
  localparam logic [31:0] A_IABR = 32'hE000_E300;
  localparam logic [31:0] A_IPR = 32'hE000_E400;
  localparam logic [31:0] A_IPR_LAST = 32'hE000_E42C;
  localparam logic [31:0] A_CTRL = 32'hE000_E4E0;
  localparam logic [31:0] A_STIR = 32'hE000_EF00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] RST_PRIO = 4'h0;
  localparam logic [GRP_W-1:0] RST_GRP = 3'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic priv;
  } ipw_req_t;

  typedef struct packed {
    logic send_event_hint;
    logic wait_for_event_hint;
    logic wait_for_interrupt_hint;
    logic supervisor_call;
    logic no_operation;
  } ipw_hint_t;

  typedef enum logic [1:0] {EXC_IRQ, EXC_NMI, EXC_SVC} ipw_kind_t;

  typedef struct packed {
    logic valid;
    ipw_kind_t kind;
    logic [ID_W-1:0] id;
  } ipw_exc_t;

  typedef enum logic [1:0] {ST_RUN, ST_WFE, ST_WFI} ipw_state_t;
endpackage

/* File: rtl/ipw_top.sv */
`timescale 1ns/10ps
// Behaviour
// - send-event hint sets local event register and pulses event to other cores
// - wait-for-event with event register set clears it and continues
// - wait-for-event with register clear sleeps until exception, debug or event
// - with event-on-pending set, a newly pending exception wakes wait-for-event
// - wait-for-interrupt sleeps until any exception or any debug request
// - supervisor call raises its exception; immediate operand is ignored
// - no-operation changes no state and takes no cycle here
// - 47 interrupt inputs, each with a 0 to 15 priority
// - lower priority number wins arbitration
// - priority splits into group and subpriority; changeable at any time
// - one nonmaskable interrupt input that masking cannot block
// - state pushed on exception entry and popped on exit by hardware
// - line high while not active makes the interrupt pending
// - rising edge on the line makes the interrupt pending
// - set-pending write or trigger register write makes it pending
// - entering the service routine moves pending to active
// - on return, line high gives pending, otherwise inactive
// - clear-pending is ignored while the line stays high
// - disabled interrupts still go pending but are never taken
// - registers decode in the two assigned private bus ranges
// - privileged registers reject unprivileged access
// - enabling a pending interrupt lets it be taken by priority
module ipw_top
  import ipw_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [IRQ_NUM-1:0] IRQ_I,
  input wire logic NMI_I,
  input wire ipw_hint_t HINT_I,
  input wire logic EVENT_I,
  input wire logic DBG_REQ_I,
  input wire logic DBG_EN_I,
  input wire logic PRIMASK_I,
  input wire ipw_exc_t EXC_ACK_I,
  input wire ipw_exc_t EXC_RET_I,
  input wire ipw_req_t REG_REQ_I,
  output logic [31:0] REG_RDATA_O,
  output ipw_exc_t EXC_REQ_O,
  output logic EVENT_O,
  output logic SLEEP_O,
  output logic STACK_PUSH_O,
  output logic STACK_POP_O
);

  function automatic logic in_bank(logic [31:0] a, logic [31:0] b);
    return (a[31:5] == b[31:5]) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [IRQ_NUM-1:0] word_to_vec(logic [2:0] w, logic [31:0] d);
    logic [63:0] t;
    t = 64'h0000_0000_0000_0000;
    if (w == 3'h0)
    begin
      t[31:0] = d;
    end
    else if (w == 3'h1)
    begin
      t[63:32] = d;
    end
    return t[IRQ_NUM-1:0];
  endfunction

  function automatic logic [31:0] vec_to_word(logic [2:0] w, logic [IRQ_NUM-1:0] v);
    logic [63:0] t;
    t = {{(64-IRQ_NUM){1'b0}}, v};
    if (w == 3'h0)
    begin
      return t[31:0];
    end
    if (w == 3'h1)
    begin
      return t[63:32];
    end
    return RST_WORD;
  endfunction

  function automatic logic [IRQ_NUM-1:0] one_hot(logic [ID_W-1:0] id);
    logic [63:0] t;
    t = 64'h0000_0000_0000_0001 << id;
    return t[IRQ_NUM-1:0];
  endfunction

  // group part: the low bits beyond the split count as subpriority only
  function automatic logic [PRIO_W-1:0] grp_of(logic [PRIO_W-1:0] p, logic [GRP_W-1:0] g);
    logic [GRP_W-1:0] n;
    n = (g > GRP_W'(PRIO_MAX_GRP)) ? g - GRP_W'(PRIO_MAX_GRP) : 3'h0;
    return p & (4'hF << n);
  endfunction

  logic [IRQ_NUM-1:0] en_q;
  logic [IRQ_NUM-1:0] pend_q;
  logic [IRQ_NUM-1:0] pend_d;
  logic [IRQ_NUM-1:0] act_q;
  logic [IRQ_NUM-1:0] irq_prev_q;
  logic [PRIO_W-1:0] prio_q [IRQ_NUM];
  logic eop_q;
  logic [GRP_W-1:0] grp_q;
  logic ev_q;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic svc_pend_q;
  ipw_state_t state_q;

  logic wr_ok;
  logic rd_ok;
  logic [2:0] wsel;
  logic [IRQ_NUM-1:0] wvec;
  logic [IRQ_NUM-1:0] en_set;
  logic [IRQ_NUM-1:0] en_clr;
  logic [IRQ_NUM-1:0] sw_set;
  logic [IRQ_NUM-1:0] sw_clr;
  logic [IRQ_NUM-1:0] stir_v;
  logic [IRQ_NUM-1:0] enter_v;
  logic [IRQ_NUM-1:0] exit_v;
  logic [IRQ_NUM-1:0] set_v;
  logic [IRQ_NUM-1:0] clr_v;
  logic priv_hit;
  logic stir_hit;
  logic ipr_hit;
  logic [3:0] ipr_idx;

  // two decode windows; only the trigger register is open to all
  assign stir_hit = (REG_REQ_I.addr == A_STIR);
  assign ipr_hit = (REG_REQ_I.addr >= A_IPR) && (REG_REQ_I.addr <= A_IPR_LAST)
                   && (REG_REQ_I.addr[1:0] == 2'b00);
  assign priv_hit = in_bank(REG_REQ_I.addr, A_ISER) || in_bank(REG_REQ_I.addr, A_ICER)
                    || in_bank(REG_REQ_I.addr, A_ISPR) || in_bank(REG_REQ_I.addr, A_ICPR)
                    || in_bank(REG_REQ_I.addr, A_IABR) || ipr_hit
                    || (REG_REQ_I.addr == A_CTRL);
  assign wr_ok = REG_REQ_I.wr && (REG_REQ_I.priv || stir_hit);
  assign rd_ok = REG_REQ_I.rd && REG_REQ_I.priv;
  assign wsel = REG_REQ_I.addr[4:2];
  assign ipr_idx = REG_REQ_I.addr[5:2];
  assign wvec = word_to_vec(wsel, REG_REQ_I.wdata);

  // misaligned offsets miss every bank and are dropped
  assign en_set = (wr_ok && in_bank(REG_REQ_I.addr, A_ISER)) ? wvec : '0;
  assign en_clr = (wr_ok && in_bank(REG_REQ_I.addr, A_ICER)) ? wvec : '0;
  assign sw_set = (wr_ok && in_bank(REG_REQ_I.addr, A_ISPR)) ? wvec : '0;
  assign sw_clr = (wr_ok && in_bank(REG_REQ_I.addr, A_ICPR)) ? wvec : '0;
  assign stir_v = (wr_ok && stir_hit && (REG_REQ_I.wdata[8:0] < 9'(IRQ_NUM)))
                  ? one_hot(REG_REQ_I.wdata[ID_W-1:0]) : '0;

  // core acknowledges entry; core reports return
  assign enter_v = (EXC_ACK_I.valid && EXC_ACK_I.kind == EXC_IRQ)
                   ? one_hot(EXC_ACK_I.id) : '0;
  assign exit_v = (EXC_RET_I.valid && EXC_RET_I.kind == EXC_IRQ)
                  ? one_hot(EXC_RET_I.id) : '0;

  // enable plays no part in going pending
  assign set_v = (IRQ_I & ~act_q & ~enter_v) | (IRQ_I & ~irq_prev_q)
                 | sw_set | stir_v | (exit_v & IRQ_I);
  // clear-pending only takes when the line is low
  assign clr_v = enter_v | (sw_clr & ~IRQ_I);
  // set wins over clear so an edge in the clear cycle is kept
  assign pend_d = set_v | (pend_q & ~clr_v);

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      pend_q <= '0;
      irq_prev_q <= '0;
    end
    else
    begin
      pend_q <= pend_d;
      irq_prev_q <= IRQ_I;
    end
  end

  // entry marks active; return drops it
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      act_q <= '0;
    end
    else
    begin
      act_q <= enter_v | (act_q & ~exit_v);
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      en_q <= '0;
    end
    else
    begin
      en_q <= en_set | (en_q & ~en_clr);
    end
  end

  // priorities may be rewritten while interrupts are live
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      for (int i = 0; i < IRQ_NUM; i++)
      begin
        prio_q[i] <= RST_PRIO;
      end
    end
    else if (wr_ok && ipr_hit)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (int'(ipr_idx) * 4 + k < IRQ_NUM)
        begin
          prio_q[int'(ipr_idx) * 4 + k] <= REG_REQ_I.wdata[8*k+PRIO_LSB +: PRIO_W];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      eop_q <= 1'b0;
      grp_q <= RST_GRP;
    end
    else if (wr_ok && REG_REQ_I.addr == A_CTRL)
    begin
      eop_q <= REG_REQ_I.wdata[CTRL_EOP_BIT];
      grp_q <= REG_REQ_I.wdata[CTRL_GRP_LSB +: GRP_W];
    end
  end

  // register read: data stand one cycle after the strobe, zero otherwise
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = RST_WORD;
    if (in_bank(REG_REQ_I.addr, A_ISER) || in_bank(REG_REQ_I.addr, A_ICER))
    begin
      rd_val = vec_to_word(wsel, en_q);
    end
    else if (in_bank(REG_REQ_I.addr, A_ISPR) || in_bank(REG_REQ_I.addr, A_ICPR))
    begin
      rd_val = vec_to_word(wsel, pend_q);
    end
    else if (in_bank(REG_REQ_I.addr, A_IABR))
    begin
      rd_val = vec_to_word(wsel, act_q);
    end
    else if (ipr_hit)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (int'(ipr_idx) * 4 + k < IRQ_NUM)
        begin
          rd_val[8*k+PRIO_LSB +: PRIO_W] = prio_q[int'(ipr_idx) * 4 + k];
        end
      end
    end
    else if (REG_REQ_I.addr == A_CTRL)
    begin
      rd_val[CTRL_EOP_BIT] = eop_q;
      rd_val[CTRL_GRP_LSB +: GRP_W] = grp_q;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      REG_RDATA_O <= RST_WORD;
    end
    else
    begin
      REG_RDATA_O <= (rd_ok && priv_hit) ? rd_val : RST_WORD;
    end
  end

  // arbitration over pending, enabled, not yet active lines
  logic best_ok;
  logic [ID_W-1:0] best_id;
  logic [PRIO_W-1:0] best_prio;
  logic run_any;
  logic [PRIO_W-1:0] run_grp;
  logic [IRQ_NUM-1:0] cand;
  assign cand = pend_q & en_q & ~act_q;

  always_comb
  begin
    best_ok = 1'b0;
    best_id = '0;
    best_prio = 4'hF;
    run_any = 1'b0;
    run_grp = 4'hF;
    for (int i = 0; i < IRQ_NUM; i++)
    begin
      // strictly lower number wins, lowest index breaks ties
      // a pending line joins as soon as it is enabled
      if (cand[i] && (!best_ok || prio_q[i] < best_prio))
      begin
        best_ok = 1'b1;
        best_id = ID_W'(i);
        best_prio = prio_q[i];
      end
      if (act_q[i] && grp_of(prio_q[i], grp_q) < run_grp)
      begin
        run_grp = grp_of(prio_q[i], grp_q);
      end
      run_any = run_any | act_q[i];
    end
  end

  // only the group part may preempt a running handler
  logic irq_take;
  assign irq_take = best_ok && !PRIMASK_I
                    && (!run_any || grp_of(best_prio, grp_q) < run_grp);

  // nonmaskable request bypasses the mask and the priority gate
  always_comb
  begin
    EXC_REQ_O = '0;
    if (nmi_pend_q)
    begin
      EXC_REQ_O.valid = 1'b1;
      EXC_REQ_O.kind = EXC_NMI;
    end
    else if (svc_pend_q)
    begin
      EXC_REQ_O.valid = 1'b1;
      EXC_REQ_O.kind = EXC_SVC;
    end
    else if (irq_take)
    begin
      EXC_REQ_O.valid = 1'b1;
      EXC_REQ_O.kind = EXC_IRQ;
      EXC_REQ_O.id = best_id;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end
    else
    begin
      nmi_prev_q <= NMI_I;
      nmi_pend_q <= (NMI_I && !nmi_prev_q)
                    || (nmi_pend_q && !(EXC_ACK_I.valid && EXC_ACK_I.kind == EXC_NMI));
    end
  end

  // immediate never reaches this block; handler reads it from the stack
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      svc_pend_q <= 1'b0;
    end
    else
    begin
      svc_pend_q <= (HINT_I.supervisor_call && state_q == ST_RUN)
                    || (svc_pend_q && !(EXC_ACK_I.valid && EXC_ACK_I.kind == EXC_SVC));
    end
  end

  // stacking strobes follow entry and return with no software step
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      STACK_PUSH_O <= 1'b0;
      STACK_POP_O <= 1'b0;
    end
    else
    begin
      STACK_PUSH_O <= EXC_ACK_I.valid;
      STACK_POP_O <= EXC_RET_I.valid;
    end
  end

  // wake and event sources
  logic run;
  logic pend_new;
  logic exc_any;
  logic ev_set;
  logic ev_use;
  assign run = (state_q == ST_RUN);
  // a fresh pending exception counts as an event when enabled
  assign pend_new = eop_q && ((|(pend_d & ~pend_q)) || (NMI_I && !nmi_prev_q));
  assign exc_any = |(pend_q & en_q) || nmi_pend_q || svc_pend_q;
  // own hint and outside events both land in the register
  assign ev_set = (HINT_I.send_event_hint && run) || EVENT_I || pend_new;
  // consumed by a hint in run, or by waking from it
  assign ev_use = (run && HINT_I.wait_for_event_hint && ev_q) || (state_q == ST_WFE && ev_q);

  // cleared at reset; a set in the clear cycle wins
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      ev_q <= 1'b0;
    end
    else
    begin
      ev_q <= ev_set || (ev_q && !ev_use);
    end
  end

  // one-cycle event to the other processors
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      EVENT_O <= 1'b0;
    end
    else
    begin
      EVENT_O <= HINT_I.send_event_hint && run;
    end
  end

  // the no-operation bit reaches no state; it needs no cycle here
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_q <= ST_RUN;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (HINT_I.wait_for_interrupt_hint)
          begin
            state_q <= ST_WFI;
          end
          // sleep only when no event is stored
          else if (HINT_I.wait_for_event_hint && !ev_q)
          begin
            state_q <= ST_WFE;
          end
        end
        ST_WFE:
        begin
          // unmasked exception, enabled debug, or stored event
          if (EXC_REQ_O.valid || (DBG_REQ_I && DBG_EN_I) || ev_q)
          begin
            state_q <= ST_RUN;
          end
        end
        ST_WFI:
        begin
          // debug wakes whether enabled or not
          if (exc_any || DBG_REQ_I)
          begin
            state_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign SLEEP_O = !run;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_sev_event_set: assert property (HINT_I.send_event_hint && run |=> ev_q && EVENT_O)
    else $error("send-event did not set event");
  a_wfe_consume: assert property (
    run && HINT_I.wait_for_event_hint && !HINT_I.wait_for_interrupt_hint && ev_q && !ev_set |=> !ev_q && run)
    else $error("wait-for-event did not consume event");
  a_wfe_sleep: assert property (
    run && HINT_I.wait_for_event_hint && !HINT_I.wait_for_interrupt_hint && !ev_q |=> state_q == ST_WFE)
    else $error("wait-for-event did not suspend");
  a_eop_wakes: assert property (
    state_q == ST_WFE && eop_q && (|(pend_d & ~pend_q)) |=> ##1 run)
    else $error("new pending did not wake");
  a_wfi_debug: assert property (state_q == ST_WFI && DBG_REQ_I |=> run)
    else $error("debug request did not wake");
  a_svc_raise: assert property (
    run && HINT_I.supervisor_call && !nmi_pend_q && !(NMI_I && !nmi_prev_q)
    |=> EXC_REQ_O.valid && EXC_REQ_O.kind == EXC_SVC)
    else $error("supervisor call not raised");
  a_nop_quiet: assert property (
    HINT_I == 5'b00001 && !EVENT_I && !pend_new && run && !ev_use
    |=> $stable(ev_q) && run)
    else $error("no-operation changed state");
  a_nmi_unmasked: assert property (
    nmi_pend_q && PRIMASK_I |-> EXC_REQ_O.valid && EXC_REQ_O.kind == EXC_NMI)
    else $error("nonmaskable request blocked");
  a_push_entry: assert property (
    EXC_ACK_I.valid |=> STACK_PUSH_O ##1 (!STACK_PUSH_O || $past(EXC_ACK_I.valid)))
    else $error("no stacking on entry");
  a_level_pend: assert property (IRQ_I[5] && !act_q[5] && !enter_v[5] |=> pend_q[5])
    else $error("level did not pend");
  a_edge_pend: assert property (IRQ_I[3] && !irq_prev_q[3] |=> pend_q[3])
    else $error("edge did not pend");
  a_enter_active: assert property (
    enter_v[3] && !exit_v[3] && !IRQ_I[3] && !sw_set[3] && !stir_v[3]
    |=> act_q[3] && !pend_q[3])
    else $error("entry did not activate");
  a_clear_held: assert property (
    sw_clr[5] && IRQ_I[5] && pend_q[5] && !enter_v[5] |=> pend_q[5])
    else $error("clear-pending took with line high");
  a_lower_wins: assert property (
    EXC_REQ_O.valid && EXC_REQ_O.kind == EXC_IRQ
    |-> !(cand[3] && prio_q[3] < prio_q[EXC_REQ_O.id]))
    else $error("higher number won arbitration");

  c_wfe_wake: cover property (state_q == ST_WFE ##1 run);
  c_wfi_wake: cover property (state_q == ST_WFI ##1 run);
  c_irq_entry: cover property (EXC_REQ_O.valid && EXC_ACK_I.valid
    && EXC_ACK_I.kind == EXC_IRQ);
  c_reenter: cover property (exit_v[5] && IRQ_I[5] ##1 pend_q[5]);
endmodule

/* File: sim/ipw_core_model.sv */
`timescale 1ns/10ps
// pipeline side: takes one handler at a time and returns it on command
module ipw_core_model
  import ipw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ack_en_i,
  input wire logic ret_go_i,
  input wire ipw_exc_t exc_req_i,
  output ipw_exc_t exc_ack_o,
  output ipw_exc_t exc_ret_o
);
  ipw_exc_t run_q;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      exc_ack_o <= '0;
      exc_ret_o <= '0;
      run_q <= '0;
    end
    else
    begin
      exc_ack_o <= '0;
      exc_ret_o <= '0;
      if (ack_en_i && exc_req_i.valid && !run_q.valid)
      begin
        exc_ack_o <= exc_req_i;
        run_q <= exc_req_i;
      end
      else if (ret_go_i && run_q.valid)
      begin
        exc_ret_o <= run_q;
        run_q <= '0;
      end
    end
  end
endmodule

/* File: sim/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb;
  import ipw_pkg::*;
  logic clk, rstn, nmi, ev_in, dbg_req, dbg_en, primask, ack_en, ret_go;
  logic [IRQ_NUM-1:0] irq;
  ipw_hint_t hint;
  ipw_req_t req;
  ipw_exc_t exc_ack, exc_ret, exc_req;
  logic [31:0] rdata;
  logic ev_out, sleep, push, pop;
  int n_errors = 0;
  int cmp_count = 0;
  int n_push = 0;
  int n_pop = 0;

  ipw_top ipw_top_i (.CORE_CLK_I(clk), .RSTN_I(rstn), .IRQ_I(irq), .NMI_I(nmi),
    .HINT_I(hint), .EVENT_I(ev_in), .DBG_REQ_I(dbg_req), .DBG_EN_I(dbg_en),
    .PRIMASK_I(primask), .EXC_ACK_I(exc_ack), .EXC_RET_I(exc_ret), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .EXC_REQ_O(exc_req), .EVENT_O(ev_out), .SLEEP_O(sleep),
    .STACK_PUSH_O(push), .STACK_POP_O(pop));
  ipw_core_model ipw_core_model_i (.clk_i(clk), .rstn_i(rstn), .ack_en_i(ack_en),
    .ret_go_i(ret_go), .exc_req_i(exc_req), .exc_ack_o(exc_ack), .exc_ret_o(exc_ret));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (push === 1'b1)
      n_push <= n_push + 1;
    if (pop === 1'b1)
      n_pop <= n_pop + 1;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // accesses are word aligned; one deliberate misaligned read checks the refusal
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic p);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0, p};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [31:0] a, input logic p, input logic [31:0] e, input string n);
    @(posedge clk);
    req <= '{a, 32'h0000_0000, 1'b0, 1'b1, p};
    @(posedge clk);
    req <= '0;
    #1;
    `CHK(n, e, rdata)
  endtask

  task automatic hnt(input logic [4:0] v);
    @(posedge clk);
    hint <= v;
    @(posedge clk);
    hint <= '0;
    #1;
  endtask

  task automatic take();
    @(posedge clk);
    ack_en <= 1'b1;
    @(posedge clk);
    ack_en <= 1'b0;
    cyc(2);
  endtask

  task automatic ret();
    @(posedge clk);
    ret_go <= 1'b1;
    @(posedge clk);
    ret_go <= 1'b0;
    cyc(2);
  endtask

  task automatic wake_by_event();
    @(posedge clk);
    ev_in <= 1'b1;
    @(posedge clk);
    ev_in <= 1'b0;
    cyc(1);
  endtask

  initial
  begin
    #100_000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    {rstn, nmi, ev_in, dbg_req, dbg_en, primask, ack_en, ret_go} = '0;
    irq = '0;
    hint = '0;
    req = '0;
    cyc(10);
    rstn <= 1'b1;
    `CHK("sleep", 1'b0, sleep)
    rd(A_ISER, 1'b1, RST_WORD, "enable reset");
    hnt(5'h01);
    `CHK("nop event", 1'b0, ev_out)
    `CHK("nop req", 1'b0, exc_req.valid)
    hnt(5'h08);
    `CHK("wfe first", 1'b1, sleep)
    wake_by_event();
    `CHK("event wake", 1'b0, sleep)
    $display("test reset_and_event done");

    hnt(5'h10);
    `CHK("sev pulse", 1'b1, ev_out)
    hnt(5'h08);
    `CHK("wfe set", 1'b0, sleep)
    hnt(5'h08);
    `CHK("wfe clear", 1'b1, sleep)
    @(posedge clk);
    dbg_req <= 1'b1;
    cyc(3);
    `CHK("dbg off", 1'b1, sleep)
    @(posedge clk);
    dbg_en <= 1'b1;
    cyc(2);
    `CHK("dbg on", 1'b0, sleep)
    @(posedge clk);
    {dbg_req, dbg_en} <= 2'b00;
    hnt(5'h04);
    `CHK("wfi", 1'b1, sleep)
    @(posedge clk);
    dbg_req <= 1'b1;
    cyc(2);
    `CHK("wfi dbg", 1'b0, sleep)
    @(posedge clk);
    dbg_req <= 1'b0;
    hnt(5'h08);
    @(posedge clk);
    irq <= 47'h0000_0000_0008;
    @(posedge clk);
    irq <= '0;
    cyc(2);
    `CHK("no pend wake", 1'b1, sleep)
    wr(A_CTRL, 32'h0000_0001, 1'b1);
    @(posedge clk);
    irq <= 47'h0000_0000_0010;
    @(posedge clk);
    irq <= '0;
    cyc(2);
    `CHK("pend wake", 1'b0, sleep)
    wr(A_CTRL, 32'h0000_0000, 1'b1);
    wr(A_ICPR, 32'h0000_0018, 1'b1);
    rd(A_ISPR, 1'b1, 32'h0000_0000, "cleared");
    $display("test hints done");

    @(posedge clk);
    irq <= 47'h0000_0000_0028;
    @(posedge clk);
    irq <= 47'h0000_0000_0020;
    rd(A_ISPR, 1'b1, 32'h0000_0028, "pend");
    `CHK("disabled", 1'b0, exc_req.valid)
    wr(A_IPR, 32'h8000_0000, 1'b1);
    wr(A_IPR + 4, 32'h0000_2000, 1'b1);
    wr(A_ISER, 32'h0000_0028, 1'b1);
    cyc(1);
    `CHK("arb", ipw_exc_t'{1'b1, EXC_IRQ, 6'h05}, exc_req)
    wr(A_IPR + 4, 32'h0000_F000, 1'b1);
    cyc(1);
    `CHK("reprio", ipw_exc_t'{1'b1, EXC_IRQ, 6'h03}, exc_req)
    take();
    rd(A_IABR, 1'b1, 32'h0000_0008, "active");
    rd(A_ISPR, 1'b1, 32'h0000_0020, "pend off");
    `CHK("nest block", 1'b0, exc_req.valid)
    ret();
    rd(A_IABR, 1'b1, 32'h0000_0000, "ret act");
    rd(A_ISPR, 1'b1, 32'h0000_0020, "ret low");
    `CHK("next", ipw_exc_t'{1'b1, EXC_IRQ, 6'h05}, exc_req)
    take();
    rd(A_ISPR, 1'b1, 32'h0000_0000, "active high");
    wr(A_STIR, 32'h0000_0003, 1'b0);
    cyc(1);
    `CHK("preempt", ipw_exc_t'{1'b1, EXC_IRQ, 6'h03}, exc_req)
    wr(A_CTRL, 32'h0000_0700, 1'b1);
    rd(A_CTRL, 1'b1, 32'h0000_0700, "split");
    `CHK("same group", 1'b0, exc_req.valid)
    wr(A_CTRL, 32'h0000_0000, 1'b1);
    wr(A_ICPR, 32'h0000_0008, 1'b1);
    ret();
    rd(A_ISPR, 1'b1, 32'h0000_0020, "ret high");
    wr(A_ICPR, 32'h0000_0020, 1'b1);
    rd(A_ISPR, 1'b1, 32'h0000_0020, "clr high");
    @(posedge clk);
    irq <= '0;
    wr(A_ICPR, 32'h0000_0020, 1'b1);
    rd(A_ISPR, 1'b1, 32'h0000_0000, "clr low");
    `CHK("pushes", 2, n_push)
    `CHK("pops", 2, n_pop)
    $display("test pending done");

    wr(A_ISER, 32'h0000_0080, 1'b0);
    rd(A_ISER, 1'b1, 32'h0000_0028, "unpriv wr");
    rd(A_ISER, 1'b0, 32'h0000_0000, "unpriv rd");
    wr(A_STIR, 32'h0000_0007, 1'b0);
    rd(A_ISPR, 1'b1, 32'h0000_0080, "trigger");
    wr(A_STIR, 32'h0000_002E, 1'b0);
    rd(A_ISPR + 4, 1'b1, 32'h0000_4000, "irq46");
    rd(32'hE000_E500, 1'b1, 32'h0000_0000, "unmapped");
    rd(A_ISER + 1, 1'b1, 32'h0000_0000, "misaligned");
    wr(A_ICPR, 32'h0000_0080, 1'b1);
    wr(A_ICPR + 4, 32'h0000_4000, 1'b1);
    rd(A_ISPR + 4, 1'b1, 32'h0000_0000, "clr46");
    wr(A_IPR_LAST, 32'hFFFF_FFFF, 1'b1);
    rd(A_IPR_LAST, 1'b1, 32'h00F0_F0F0, "prio last");
    $display("test access done");

    @(posedge clk);
    primask <= 1'b1;
    hnt(5'h02);
    `CHK("svc", {1'b1, EXC_SVC}, {exc_req.valid, exc_req.kind})
    @(posedge clk);
    nmi <= 1'b1;
    cyc(1);
    `CHK("nmi", {1'b1, EXC_NMI}, {exc_req.valid, exc_req.kind})
    take();
    ret();
    `CHK("svc after", {1'b1, EXC_SVC}, {exc_req.valid, exc_req.kind})
    take();
    ret();
    `CHK("idle", 1'b0, exc_req.valid)
    `CHK("pushes", 4, n_push)
    `CHK("pops", 4, n_pop)
    $display("test exceptions done");
    complete_run();
  end
endmodule
